// ### rtl/datsi_pkg.sv
// Purpose: Shared constants, types and helpers for the serial audio input stage.
// Assumes: One clock (aclk, 250 MHz); all serial inputs are asynchronous to it.
// Notes:   Register map sits on an AXI4-Lite slave with 32-bit data.

package datsi_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_ROUTE = 8'h04;
   localparam logic [7:0] ADDR_PCG_DIV = 8'h08;
   localparam logic [7:0] ADDR_OSC_DIV = 8'h0C;
   localparam logic [7:0] ADDR_LEFT = 8'h10;
   localparam logic [7:0] ADDR_RIGHT = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;

   localparam logic [31:0] CTRL_RESET = 32'h0000_0011;
   localparam logic [31:0] ROUTE_RESET = 32'h0000_0000;
   localparam logic [31:0] PCG_DIV_RESET = 32'h0000_0004;
   localparam logic [31:0] OSC_DIV_RESET = 32'h0000_0002;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // ------------------------------------------------------------
   // Framing
   // ------------------------------------------------------------
   localparam logic [5:0] SCLK_PER_HALF = 6'h20;
   localparam logic [5:0] CNT_MAX = 6'h3F;
   localparam int SAMPLE_W = 24;

   typedef enum logic [1:0] {
      FMT_LEFT = 2'b00,
      FMT_I2S = 2'b01,
      FMT_RIGHT = 2'b10
   } datsi_fmt_t;

   typedef enum logic [1:0] {
      SRC_PIN = 2'b00,
      SRC_PCG = 2'b01,
      SRC_PORT = 2'b10
   } datsi_src_t;

   // Control word: [1:0] format, [3:2] width select, [4] enable.
   typedef struct packed {
      logic [26:0] rsvd;
      logic enable;
      logic [1:0] wsel;
      datsi_fmt_t fmt;
   } datsi_ctrl_t;

   // Routing word: pin indices for clock, sync, data and generator input.
   typedef struct packed {
      logic [16:0] rsvd;
      logic [2:0] pcg_pin;
      logic pcg_from_pin;
      logic [2:0] data_pin;
      logic [2:0] fs_pin;
      logic [2:0] sclk_pin;
      datsi_src_t clk_src;
   } datsi_route_t;

   typedef struct packed {
      logic left;
      logic [SAMPLE_W-1:0] data;
   } datsi_word_t;

   function automatic logic [5:0] width_of(input logic [1:0] wsel);
      case (wsel)
         2'h0: width_of = 6'h10;
         2'h1: width_of = 6'h12;
         2'h2: width_of = 6'h14;
         default: width_of = 6'h18;
      endcase
   endfunction : width_of

   function automatic logic [5:0] msb_offset(input datsi_fmt_t fmt, input logic [1:0] wsel);
      case (fmt)
         FMT_LEFT: msb_offset = 6'h00;
         FMT_RIGHT: msb_offset = SCLK_PER_HALF - width_of(wsel);
         default: msb_offset = 6'h01;
      endcase
   endfunction : msb_offset

endpackage : datsi_pkg

// ### rtl/datsi_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for a group of pins.
// Assumes: Inputs are asynchronous to aclk.
// Notes:   Output follows only when the second and third stage agree.

`timescale 1ns/10ps

module datsi_sync
   import datsi_pkg::*;
#(
   parameter int W = 4
)
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Data
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);

   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   logic [W-1:0] stable_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         stable_reg <= '0;
      end
      else
      begin
         s1_reg <= din;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         // A bit that differs between stages is still settling, so it holds.
         stable_reg <= (s3_reg & ~(s2_reg ^ s3_reg)) | (stable_reg & (s2_reg ^ s3_reg));
      end
   end

   assign dout = stable_reg;

endmodule : datsi_sync

// ### rtl/datsi_top.sv
// Purpose: Serial audio input formatter with routing, clock generator and oversampling divider.
// Assumes: Serial clock is slow against aclk (at least 80 ns period against 4 ns).
// Notes:   Registers are reached over AXI4-Lite; unmapped addresses answer DECERR.

`timescale 1ns/10ps

module datsi_top
   import datsi_pkg::*;
#(
   parameter int NPINS = 8
)
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Pins and sources
   input wire logic [NPINS-1:0] external_audio_pin,
   input wire logic main_clock_input_pin,
   input wire logic port_sclk,
   input wire logic port_fs,
   input wire logic oversampling_clock,
   // Encoder side
   output logic word_valid,
   output datsi_word_t word_out,
   output logic pair_valid,
   output logic [SAMPLE_W-1:0] pair_left,
   output logic [SAMPLE_W-1:0] pair_right,
   output logic biphase_clock,
   output logic biphase_tick
);

   // ------------------------------------------------------------
   // Register file and AXI4-Lite slave
   // ------------------------------------------------------------
   logic [31:0] ctrl_word_reg;
   logic [31:0] route_word_reg;
   logic [15:0] pcg_div_reg;
   logic [7:0] osc_div_reg;
   logic [15:0] pair_cnt_reg;
   logic aw_have_reg;
   logic w_have_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic do_write;
   datsi_ctrl_t ctrl;
   datsi_route_t route;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
      for (int i = 0; i < 4; i++)
      begin
         merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
      end
   endfunction : merge

   assign ctrl = datsi_ctrl_t'(ctrl_word_reg);
   assign route = datsi_route_t'(route_word_reg);
   assign s_axi_awready = !aw_have_reg && !bvalid_reg;
   assign s_axi_wready = !w_have_reg && !bvalid_reg;
   assign do_write = aw_have_reg && w_have_reg && !bvalid_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_have_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= (aw_addr_reg[7:2] <= ADDR_STATUS[7:2]) ? RESP_OKAY : RESP_DECERR;
         end
         else if (bvalid_reg && s_axi_bready)
         begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_word_reg <= CTRL_RESET;
         route_word_reg <= ROUTE_RESET;
         pcg_div_reg <= PCG_DIV_RESET[15:0];
         osc_div_reg <= OSC_DIV_RESET[7:0];
      end
      else if (do_write)
      begin
         case ({aw_addr_reg[7:2], 2'b00})
            ADDR_CTRL: ctrl_word_reg <= merge(ctrl_word_reg, w_data_reg, w_strb_reg) & 32'h0000_001F;
            ADDR_ROUTE: route_word_reg <= merge(route_word_reg, w_data_reg, w_strb_reg) & 32'h0000_7FFF;
            ADDR_PCG_DIV: pcg_div_reg <= 16'(merge({16'h0000, pcg_div_reg}, w_data_reg, w_strb_reg));
            ADDR_OSC_DIV: osc_div_reg <= w_strb_reg[0] ? w_data_reg[7:0] : osc_div_reg;
            default: ctrl_word_reg <= ctrl_word_reg;
         endcase
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         rvalid_reg <= 1'b1;
         rresp_reg <= RESP_OKAY;
         case ({s_axi_araddr[7:2], 2'b00})
            ADDR_CTRL: rdata_reg <= ctrl_word_reg;
            ADDR_ROUTE: rdata_reg <= route_word_reg;
            ADDR_PCG_DIV: rdata_reg <= {16'h0000, pcg_div_reg};
            ADDR_OSC_DIV: rdata_reg <= {24'h000000, osc_div_reg};
            ADDR_LEFT: rdata_reg <= {8'h00, pair_left};
            ADDR_RIGHT: rdata_reg <= {8'h00, pair_right};
            ADDR_STATUS: rdata_reg <= {16'h0000, pair_cnt_reg};
            default:
            begin
               rdata_reg <= 32'h0000_0000;
               rresp_reg <= RESP_DECERR;
            end
         endcase
      end
      else if (rvalid_reg && s_axi_rready)
      begin
         rvalid_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Synchronisers and signal routing
   // ------------------------------------------------------------
   logic [NPINS+3:0] pins_s;
   logic [NPINS-1:0] ext_s;
   logic pcg_sclk_reg;
   logic pcg_fs_reg;
   logic sclk_sel;
   logic fs_sel;
   logic data_sel;

   datsi_sync #(.W(NPINS + 4)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .din({oversampling_clock, port_fs, port_sclk, main_clock_input_pin, external_audio_pin}),
      .dout(pins_s)
   );

   assign ext_s = pins_s[NPINS-1:0];
   assign data_sel = ext_s[route.data_pin];

   always_comb
   begin
      case (route.clk_src)
         SRC_PCG:
         begin
            sclk_sel = pcg_sclk_reg;
            fs_sel = pcg_fs_reg;
         end
         SRC_PORT:
         begin
            sclk_sel = pins_s[NPINS+1];
            fs_sel = pins_s[NPINS+2];
         end
         default:
         begin
            sclk_sel = ext_s[route.sclk_pin];
            fs_sel = ext_s[route.fs_pin];
         end
      endcase
   end

   // ------------------------------------------------------------
   // Programmable clock generator
   // ------------------------------------------------------------
   logic pcg_in;
   logic pcg_in_q_reg;
   logic [15:0] pcg_cnt_reg;
   logic [4:0] pcg_bit_reg;

   assign pcg_in = route.pcg_from_pin ? ext_s[route.pcg_pin] : pins_s[NPINS];

   // Frame sync flips on a falling serial clock so it is steady at the rising one.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pcg_in_q_reg <= 1'b0;
         pcg_cnt_reg <= 16'h0000;
         pcg_sclk_reg <= 1'b0;
         pcg_fs_reg <= 1'b0;
         pcg_bit_reg <= 5'h00;
      end
      else
      begin
         pcg_in_q_reg <= pcg_in;
         if (pcg_in && !pcg_in_q_reg)
         begin
            if (pcg_cnt_reg + 16'h0001 >= pcg_div_reg)
            begin
               pcg_cnt_reg <= 16'h0000;
               pcg_sclk_reg <= !pcg_sclk_reg;
               if (pcg_sclk_reg)
               begin
                  pcg_bit_reg <= pcg_bit_reg + 5'h01;
                  if (pcg_bit_reg == 5'h1F)
                  begin
                     pcg_fs_reg <= !pcg_fs_reg;
                  end
               end
            end
            else
            begin
               pcg_cnt_reg <= pcg_cnt_reg + 16'h0001;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Oversampling clock divider
   // ------------------------------------------------------------
   logic osc_q_reg;
   logic osc_rise;
   logic [7:0] osc_cnt_reg;
   logic biphase_reg;
   logic tick_reg;

   assign osc_rise = pins_s[NPINS+3] && !osc_q_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         osc_q_reg <= 1'b0;
         osc_cnt_reg <= 8'h00;
         biphase_reg <= 1'b0;
         tick_reg <= 1'b0;
      end
      else
      begin
         osc_q_reg <= pins_s[NPINS+3];
         tick_reg <= 1'b0;
         if (osc_rise)
         begin
            if (osc_cnt_reg + 8'h01 >= osc_div_reg)
            begin
               osc_cnt_reg <= 8'h00;
               biphase_reg <= !biphase_reg;
               tick_reg <= 1'b1;
            end
            else
            begin
               osc_cnt_reg <= osc_cnt_reg + 8'h01;
            end
         end
      end
   end

   assign biphase_clock = biphase_reg;
   assign biphase_tick = tick_reg;

   // ------------------------------------------------------------
   // Serial receiver
   // ------------------------------------------------------------
   logic sclk_q_reg;
   logic sclk_rise;
   logic fs_prev_reg;
   logic framed_reg;
   logic fs_edge;
   logic [5:0] bit_cnt_reg;
   logic [5:0] bit_idx;
   logic [5:0] off;
   logic [5:0] wid;
   logic in_word;
   logic last_bit;
   logic [SAMPLE_W-1:0] shift_reg;
   logic [SAMPLE_W-1:0] shift_next;
   logic chan_left;

   assign sclk_rise = sclk_sel && !sclk_q_reg;
   assign fs_edge = fs_sel != fs_prev_reg;
   assign bit_idx = fs_edge ? 6'h00 : bit_cnt_reg;
   assign off = msb_offset(ctrl.fmt, ctrl.wsel);
   assign wid = width_of(ctrl.wsel);
   assign in_word = (bit_idx >= off) && (bit_idx < off + wid);
   assign last_bit = bit_idx == off + wid - 6'h01;
   assign shift_next = {shift_reg[SAMPLE_W-2:0], data_sel};
   assign chan_left = (ctrl.fmt == FMT_I2S) ? !fs_sel : fs_sel;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sclk_q_reg <= 1'b0;
         fs_prev_reg <= 1'b0;
         framed_reg <= 1'b0;
         bit_cnt_reg <= 6'h00;
         shift_reg <= '0;
      end
      else
      begin
         sclk_q_reg <= sclk_sel;
         if (sclk_rise)
         begin
            fs_prev_reg <= fs_sel;
            // Words are only taken once a sync edge has set framed_reg, so a mid-frame start is dropped.
            if (fs_edge)
            begin
               framed_reg <= ctrl.enable;
            end
            bit_cnt_reg <= (bit_idx == CNT_MAX) ? CNT_MAX : bit_idx + 6'h01;
            if (in_word)
            begin
               shift_reg <= shift_next;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Word and pair delivery
   // ------------------------------------------------------------
   logic word_valid_reg;
   datsi_word_t word_reg;
   logic pair_valid_reg;
   logic left_have_reg;
   logic [SAMPLE_W-1:0] left_reg;
   logic [SAMPLE_W-1:0] right_reg;
   logic word_done;
   logic [SAMPLE_W-1:0] aligned;

   assign word_done = sclk_rise && in_word && last_bit && (framed_reg || fs_edge) && ctrl.enable;
   assign aligned = shift_next << (6'(SAMPLE_W) - wid);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         word_valid_reg <= 1'b0;
         word_reg <= '0;
         pair_valid_reg <= 1'b0;
         left_have_reg <= 1'b0;
         left_reg <= '0;
         right_reg <= '0;
         pair_cnt_reg <= 16'h0000;
      end
      else
      begin
         word_valid_reg <= word_done;
         pair_valid_reg <= 1'b0;
         if (word_done)
         begin
            word_reg <= '{left: chan_left, data: aligned};
            if (chan_left)
            begin
               left_reg <= aligned;
               left_have_reg <= 1'b1;
            end
            else if (left_have_reg)
            begin
               right_reg <= aligned;
               left_have_reg <= 1'b0;
               pair_valid_reg <= 1'b1;
               pair_cnt_reg <= pair_cnt_reg + 16'h0001;
            end
         end
      end
   end

   assign word_valid = word_valid_reg;
   assign word_out = word_reg;
   assign pair_valid = pair_valid_reg;
   assign pair_left = left_reg;
   assign pair_right = right_reg;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   fmt_after_reset_a: assert property ($past(!aresetn) |-> ctrl.fmt == FMT_I2S)
      else $error("Format is not inter-IC-sound after reset.");
   word_on_rise_a: assert property (word_valid |-> $past(sclk_rise))
      else $error("Word completed without a serial clock rising edge.");
   tag_i2s_a: assert property (word_valid && $past(ctrl.fmt) == FMT_I2S |-> word_out.left == !$past(fs_sel))
      else $error("Inter-IC-sound channel tag does not match frame sync.");
   tag_just_a: assert property (word_valid && $past(ctrl.fmt) != FMT_I2S |-> word_out.left == $past(fs_sel))
      else $error("Justified channel tag does not match frame sync.");
   rj_lsb_end_a: assert property (word_valid && $past(ctrl.fmt) == FMT_RIGHT |-> $past(bit_idx) == 6'h1F)
      else $error("Right justified LSB not just before the next sync edge.");
   rj_msb_at_a: assert property (sclk_rise && ctrl.fmt == FMT_RIGHT && ctrl.wsel == 2'h3 &&
      (bit_idx == 6'h07 || bit_idx == 6'h08) |-> in_word == (bit_idx == 6'h08))
      else $error("Right justified 24-bit MSB not at clock eight.");
   i2s_lsb_a: assert property (word_valid && $past(ctrl.fmt) == FMT_I2S |-> $past(bit_idx) == $past(wid))
      else $error("Inter-IC-sound word does not end one clock late.");
   lj_lsb_a: assert property (word_valid && $past(ctrl.fmt) == FMT_LEFT |-> $past(bit_idx) == $past(wid) - 6'h01)
      else $error("Left justified word does not start at the sync edge.");
   width_pad_a: assert property (word_valid && $past(ctrl.wsel) == 2'h0 |-> word_out.data[7:0] == 8'h00)
      else $error("A 16-bit word carries bits below its LSB.");
   pair_right_a: assert property (pair_valid |-> word_valid && !word_out.left && word_out.data == pair_right)
      else $error("Pair delivered without a right word.");
   biphase_cause_a: assert property ($changed(biphase_clock) |-> $past(osc_rise) ##1 !biphase_tick)
      else $error("Biphase clock moved without an oversampling edge.");
   bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("Write response dropped before it was taken.");

   i2s_pair_c: cover property (pair_valid && ctrl.fmt == FMT_I2S);
   rj_pair_c: cover property (pair_valid && ctrl.fmt == FMT_RIGHT && ctrl.wsel == 2'h2);
   lj_word_c: cover property (word_valid && ctrl.fmt == FMT_LEFT && ctrl.wsel == 2'h1);
   pcg_word_c: cover property (word_valid && route.clk_src == SRC_PCG);

endmodule : datsi_top

// ### test/datsi_sender.sv
// Purpose: Serial audio sender standing in for the routed far side.
// Assumes: 80 ns serial clock, 64 serial clocks per frame, left half first.
// Notes:   Bits outside the word alternate, so a stale value never matches.
`timescale 1ns/10ps
module datsi_sender
   import datsi_pkg::*;
(
   // Link
   output logic sclk,
   output logic fs,
   output logic sdata,
   // Frame content
   input wire logic [1:0] fmt,
   input wire logic [1:0] wsel,
   input wire logic [23:0] lsamp,
   input wire logic [23:0] rsamp
);
   int w;
   int k;
   logic left;
   always
   begin
      for (int i = 0; i < 64; i++)
      begin
         sclk = 1'b0;
         w = (wsel == 2'h3) ? 24 : 16 + 2 * wsel;
         k = i % 32 - ((fmt == FMT_LEFT) ? 0 : (fmt == FMT_I2S) ? 1 : 32 - w);
         left = (i < 32);
         fs = (fmt == FMT_I2S) ? !left : left;
         sdata = (k >= 0 && k < w) ? (left ? lsamp[23 - k] : rsamp[23 - k]) : k[0];
         #40 sclk = 1'b1;
         #40;
      end
   end
endmodule : datsi_sender

// ### test/datsi_top_tb.sv
// Purpose: Self-checking bench for the serial audio input formatter.
// Assumes: Pins 0, 1 and 2 carry serial clock, frame sync and data.
// Notes:   Each setting runs three frames; only the last pair is judged.
`timescale 1ns/10ps
module datsi_top_tb
   import datsi_pkg::*;
;
   logic aclk = 1'b0, aresetn = 1'b0, osc = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, d;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, r, f = 2'h1, ws = 2'h0;
   logic word_valid, pair_valid, biphase_clock, biphase_tick, sclk, fs, sdata;
   datsi_word_t word_out;
   logic [23:0] pair_left, pair_right, lv = 24'h0, rv = 24'h0, mask;
   int fail_count = 0, comparisons = 0, ticks = 0, t0;

   always #2 aclk = ~aclk;
   always #12 osc = ~osc;
   always @(posedge aclk) if (biphase_tick === 1'b1) ticks <= ticks + 1;

   datsi_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata(d), .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .external_audio_pin({5'h00, sdata, fs, sclk}), .main_clock_input_pin(1'b0),
      .port_sclk(sclk), .port_fs(fs), .oversampling_clock(osc), .word_valid, .word_out, .pair_valid,
      .pair_left, .pair_right, .biphase_clock, .biphase_tick);
   datsi_sender far_end (.sclk, .fs, .sdata, .fmt(f), .wsel(ws), .lsamp(lv), .rsamp(rv));

   // ------------------------------------------------------------
   // Bus tasks
   // ------------------------------------------------------------
   // Ready is sampled at the falling edge; it cannot change before the next rising edge.
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
      logic ah, wh, bh;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever
      begin
         @(negedge aclk);
         ah = s_axi_awvalid & s_axi_awready;
         wh = s_axi_wvalid & s_axi_wready;
         bh = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge aclk);
         if (ah) s_axi_awvalid <= 1'b0;
         if (wh) s_axi_wvalid <= 1'b0;
         if (bh) break;
      end
      s_axi_bready <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] v);
      logic ah, rh;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever
      begin
         @(negedge aclk);
         ah = s_axi_arvalid & s_axi_arready;
         rh = s_axi_rvalid;
         v = d;
         r = s_axi_rresp;
         @(posedge aclk);
         if (ah) s_axi_arvalid <= 1'b0;
         if (rh) break;
      end
      s_axi_rready <= 1'b0;
   endtask : axi_rd

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic end_of_test();
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_of_test

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial
   begin
      repeat (85000) @(posedge aclk);
      fail_count++;
      end_of_test();
   end

   initial
   begin
      logic [31:0] v, st;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(ADDR_CTRL, v);
      check("ctrl reset", v, CTRL_RESET);
      axi_rd(8'h20, v);
      check("unmapped read", {30'h0, r}, {30'h0, RESP_DECERR});
      axi_wr(8'h20, 32'h1);
      check("unmapped write", {30'h0, r}, {30'h0, RESP_DECERR});
      t0 = ticks;
      axi_wr(ADDR_ROUTE, 32'h0000_0220);
      check("route write", {30'h0, r}, {30'h0, RESP_OKAY});
      repeat (200) @(posedge aclk);
      @(negedge aclk);
      check("biphase ticks", 32'(ticks - t0 >= 15 && ticks - t0 <= 19), 32'h1);
      check("biphase level", {31'h0, biphase_clock ^ biphase_tick}, {31'h0, ticks[0]});
      // The last pass takes clock and sync from the on-chip serial port instead of the pins.
      for (int j = 0; j < 13; j++)
      begin
         if (j == 12) axi_wr(ADDR_ROUTE, 32'h0000_0222);
         axi_wr(ADDR_CTRL, {27'h0, 1'b1, (j == 12) ? 2'h3 : 2'(j % 4), (j == 12) ? 2'h1 : 2'(j / 4)});
         f <= (j == 12) ? 2'h1 : 2'(j / 4);
         ws <= (j == 12) ? 2'h3 : 2'(j % 4);
         lv <= 24'hC6A59F ^ 24'(j << 12);
         rv <= 24'h3B5A61 ^ 24'(j << 16);
         @(posedge aclk);
         mask = 24'hFFFFFF << (24 - ((ws == 2'h3) ? 24 : 16 + 2 * ws));
         repeat (3)
         begin
            do @(negedge aclk); while (pair_valid !== 1'b1);
         end
         check("pair left", {8'h00, pair_left}, {8'h00, lv & mask});
         check("pair right", {8'h00, pair_right}, {8'h00, rv & mask});
         check("right tag", {31'h0, word_out.left}, 32'h0);
      end
      axi_rd(ADDR_LEFT, v);
      check("left register", v, {8'h00, lv & mask});
      axi_rd(ADDR_STATUS, st);
      axi_wr(ADDR_CTRL, 32'h0000_0001);
      repeat (3000) @(posedge aclk);
      axi_rd(ADDR_STATUS, v);
      check("pairs while disabled", v, st);
      end_of_test();
   end
endmodule : datsi_top_tb
